// ==== hw/sws_sequencer.v ====
// Purpose: per-channel stimulation waveform sequencer
// Assumes: tick_i pulses once per sample period, synchronous inputs
// Notes: segment list and biphasic waveform modes, one channel
`timescale 1ns/10ps
`default_nettype none
`include "sws_defs.vh"

// Operation
// - Segment 0 is resting level, held before trigger and after; length ignored
// - After trigger, segments play in order, each for its length in timesteps
// - Loop start..end repeats forever on -1, else the given extra count
// - Infinite repeat jumps loop end back to loop start until stopped
// - Channel index must be 0 to 15; otherwise validation error
// - Trigger source 0 is none, 1 is button rising edge, others reserved
// - Pulse count pulses per trigger, one gives single pulse, max 99
// - Multiple pulses start train period apart; single pulse needs zero period
// - Resting amplitude before, after pulses and during nonzero interphase gap
// - First phase amplitude for its duration; zero duration skips it
// - Interphase gap at rest for its duration; zero inserts no gap
// - Second phase amplitude for its duration; zero duration skips it
// - Wait post-trigger delay before first phase; zero starts immediately
// - Triggers ignored for refractory period after second phase ends
// - Refractory must cover post settle and recovery on and off times
// - Settle asserted pre-settle count before first phase; count within delay
// - Settle kept asserted post-settle count after second phase ends
// - Settle-maintain holds settle across whole train including idle gaps
// - Recovery on after on-count, off after off-count from second phase end
// - Any violation halts permanently, lights error lamp, sets bad waveform flag
// - Disabled settle or recovery features require their fields zero
// - Build options select settle method and recovery method
// - One timestep equals one sample tick period, 50 us at 20 kHz
// - Segments carry settle and recovery bits applied while active
// - Trigger index limited to number of slots, default two
module sws_sequencer #(
  parameter TRAD_FAST_SETTLE = 1,
  parameter RECOVERY_SWITCH = 1
) (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire tick_i,
  input wire enable_i,
  input wire seg_mode_i,
  input wire button_trigger_pin,
  input wire [`SWS_TRIG_W-1:0] trig_source_i,
  input wire [`SWS_CHAN_W-1:0] channel_i,
  input wire [`SWS_PULSE_W-1:0] num_pulses_i,
  input wire [`SWS_CNT_W-1:0] train_period_i,
  input wire [`SWS_AMP_W-1:0] rest_amp_i,
  input wire [`SWS_AMP_W-1:0] ph1_amp_i,
  input wire [`SWS_AMP_W-1:0] ph2_amp_i,
  input wire [`SWS_CNT_W-1:0] delay_i,
  input wire [`SWS_CNT_W-1:0] ph1_dur_i,
  input wire [`SWS_CNT_W-1:0] gap_dur_i,
  input wire [`SWS_CNT_W-1:0] ph2_dur_i,
  input wire [`SWS_CNT_W-1:0] refr_i,
  input wire settle_en_i,
  input wire [`SWS_CNT_W-1:0] pre_settle_i,
  input wire [`SWS_CNT_W-1:0] post_settle_i,
  input wire settle_hold_i,
  input wire recov_en_i,
  input wire [`SWS_CNT_W-1:0] recov_on_i,
  input wire [`SWS_CNT_W-1:0] recov_off_i,
  input wire seg_we_i,
  input wire [`SWS_SEG_AW-1:0] seg_waddr_i,
  input wire [`SWS_CNT_W-1:0] seg_len_i,
  input wire [`SWS_AMP_W-1:0] seg_amp_i,
  input wire seg_settle_i,
  input wire seg_recov_i,
  input wire [`SWS_SEG_AW-1:0] seg_last_i,
  input wire [`SWS_SEG_AW-1:0] loop_start_i,
  input wire [`SWS_SEG_AW-1:0] loop_end_i,
  input wire [`SWS_REP_W-1:0] loop_rep_i,
  output reg [`SWS_AMP_W-1:0] amp_o,
  output reg [3:0] chan_o,
  output reg fast_settle_o,
  output reg cutoff_switch_o,
  output reg recov_switch_o,
  output reg recov_limit_o,
  output reg active_o,
  output reg refractory_o,
  output reg bad_waveform_flag,
  output reg error_led_o
);

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_DELAY = 7'h02;
  localparam [6:0] ST_PH1 = 7'h04;
  localparam [6:0] ST_GAP = 7'h08;
  localparam [6:0] ST_PH2 = 7'h10;
  localparam [6:0] ST_WAIT = 7'h20;
  localparam [6:0] ST_SEG = 7'h40;

  // Segment table, small enough for flops
  reg [`SWS_CNT_W-1:0] seg_len_m [0:`SWS_SEG_NUM-1];
  reg [`SWS_AMP_W-1:0] seg_amp_m [0:`SWS_SEG_NUM-1];
  reg [1:0] seg_ctl_m [0:`SWS_SEG_NUM-1];

  reg [6:0] state_r;
  reg [`SWS_CNT_W-1:0] cnt_r;
  reg [`SWS_CNT_W-1:0] per_r;
  reg [`SWS_CNT_W-1:0] post_r;
  reg [`SWS_PULSE_W-1:0] pulses_r;
  reg [`SWS_SEG_AW-1:0] seg_r;
  reg [`SWS_REP_W-1:0] rep_r;
  reg post_run_r;
  reg button_q_r;
  reg settle_r;
  reg recov_r;
  reg [`SWS_AMP_W-1:0] amp_r;
  wire trig_fire;
  wire cfg_bad;
  wire [`SWS_CNT_W-1:0] post_max;
  wire ph1_on;
  wire gap_on;
  wire ph2_on;
  reg [6:0] phase_nxt;
  reg step_done;

  // Larger of two counts, used twice
  function [`SWS_CNT_W-1:0] cmax;
    input [`SWS_CNT_W-1:0] a;
    input [`SWS_CNT_W-1:0] b;
    begin
      cmax = (a > b) ? a : b;
    end
  endfunction

  // First step at or after 'from' whose length is nonzero; idle marks end
  function [6:0] skip_to;
    input [1:0] from;
    input n1;
    input ng;
    input n2;
    begin
      if (from == 2'h0 && n1)
        skip_to = ST_PH1;
      else if (from <= 2'h1 && ng)
        skip_to = ST_GAP;
      else if (from <= 2'h2 && n2)
        skip_to = ST_PH2;
      else
        skip_to = ST_IDLE;
    end
  endfunction

  assign ph1_on = (ph1_dur_i != 24'h000000);
  assign gap_on = (gap_dur_i != 24'h000000);
  assign ph2_on = (ph2_dur_i != 24'h000000);

  // Step end and successor; zero phases are skipped, not played for a tick
  always @* begin
    step_done = 1'b0;
    phase_nxt = ST_IDLE;
    case (state_r)
      ST_DELAY: begin
        step_done = (cnt_r >= delay_i);
        phase_nxt = skip_to(2'h0, ph1_on, gap_on, ph2_on);
      end
      ST_WAIT: begin
        step_done = (per_r + 24'h000001 >= train_period_i);
        phase_nxt = skip_to(2'h0, ph1_on, gap_on, ph2_on);
      end
      ST_PH1: begin
        step_done = (cnt_r + 24'h000001 >= ph1_dur_i);
        phase_nxt = skip_to(2'h1, ph1_on, gap_on, ph2_on);
      end
      ST_GAP: begin
        step_done = (cnt_r + 24'h000001 >= gap_dur_i);
        phase_nxt = skip_to(2'h2, ph1_on, gap_on, ph2_on);
      end
      ST_PH2: begin
        step_done = (cnt_r + 24'h000001 >= ph2_dur_i);
        phase_nxt = skip_to(2'h3, ph1_on, gap_on, ph2_on);
      end
      default: begin
        step_done = 1'b0;
        phase_nxt = ST_IDLE;
      end
    endcase
  end

  // Amplitude follows the state, so a phase shows on the tick it starts
  always @* begin
    amp_r = rest_amp_i;
    case (state_r)
      ST_IDLE: amp_r = seg_mode_i ? seg_amp_m[0] : rest_amp_i;
      ST_PH1: amp_r = ph1_amp_i;
      ST_GAP: amp_r = rest_amp_i;
      ST_PH2: amp_r = ph2_amp_i;
      ST_SEG: amp_r = seg_amp_m[seg_r];
      default: amp_r = rest_amp_i;
    endcase
  end

  // Validation of the loaded parameters
  assign post_max = cmax(post_settle_i, cmax(recov_on_i, recov_off_i));
  assign cfg_bad = (channel_i >= `SWS_NUM_CHAN) |
    (trig_source_i > `SWS_NUM_SLOTS) |
    (!seg_mode_i && (num_pulses_i == 8'h00 ||
      num_pulses_i > `SWS_MAX_PULSES)) |
    (!seg_mode_i && num_pulses_i == 8'h01 &&
      train_period_i != 24'h000000) |
    (!seg_mode_i && refr_i < post_max) |
    (settle_en_i && pre_settle_i > delay_i) |
    (recov_en_i && recov_off_i < recov_on_i) |
    (!settle_en_i && (pre_settle_i != 24'h000000 ||
      post_settle_i != 24'h000000 || settle_hold_i)) |
    (!recov_en_i && (recov_on_i != 24'h000000 ||
      recov_off_i != 24'h000000)) |
    (seg_mode_i && (loop_end_i < loop_start_i ||
      loop_end_i > seg_last_i || loop_start_i == 3'h0));

  // Only source 1 is wired; reserved sources never fire
  assign trig_fire = (trig_source_i == `SWS_TRIG_BUTTON) &&
    button_trigger_pin && !button_q_r;

  // Segment table writes
  always @(posedge clk_sys_i) begin
    if (seg_we_i) begin
      seg_len_m[seg_waddr_i] <= seg_len_i;
      seg_amp_m[seg_waddr_i] <= seg_amp_i;
      seg_ctl_m[seg_waddr_i] <= {seg_settle_i, seg_recov_i};
    end
  end

  // Main sequencer, advances only on the timestep tick
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_r <= ST_IDLE;
      cnt_r <= 24'h000000;
      per_r <= 24'h000000;
      post_r <= 24'h000000;
      pulses_r <= 8'h00;
      seg_r <= 3'h0;
      rep_r <= 16'h0000;
      post_run_r <= 1'b0;
      button_q_r <= 1'b0;
      settle_r <= 1'b0;
      recov_r <= 1'b0;
      bad_waveform_flag <= 1'b0;
      error_led_o <= 1'b0;
      refractory_o <= 1'b0;
    end else if (enable_i && cfg_bad) begin
      // Error sticks until reset: treat as a halt
      bad_waveform_flag <= 1'b1;
      error_led_o <= 1'b1;
      state_r <= ST_IDLE;
      settle_r <= 1'b0;
      recov_r <= 1'b0;
    end else if (tick_i && !bad_waveform_flag) begin
      button_q_r <= button_trigger_pin;
      // Post-pulse windows run off their own counter
      if (post_run_r && !seg_mode_i) begin
        post_r <= post_r + 24'h000001;
        if (post_r + 24'h000001 >= refr_i)
          post_run_r <= 1'b0;
      end
      if (!seg_mode_i)
        refractory_o <= post_run_r &&
          (post_r + 24'h000001 < refr_i);
      if (!seg_mode_i)
        recov_r <= recov_en_i && post_run_r &&
          post_r >= recov_on_i && post_r < recov_off_i;
      if (state_r != ST_IDLE && state_r != ST_SEG)
        per_r <= per_r + 24'h000001;
      case (state_r)
        ST_IDLE: begin
          settle_r <= !seg_mode_i && settle_en_i && post_run_r &&
            post_r < post_settle_i;
          if (seg_mode_i) begin
            {settle_r, recov_r} <= seg_ctl_m[0];
          end
          if (trig_fire && enable_i && !refractory_o) begin
            if (seg_mode_i) begin
              state_r <= ST_SEG;
              seg_r <= 3'h1;
              cnt_r <= 24'h000000;
              rep_r <= loop_rep_i;
            end else begin
              state_r <= ST_DELAY;
              cnt_r <= 24'h000000;
              per_r <= 24'h000000;
              pulses_r <= num_pulses_i;
              post_run_r <= 1'b0;
            end
          end
        end
        ST_DELAY, ST_WAIT, ST_PH1, ST_GAP, ST_PH2: begin
          cnt_r <= cnt_r + 24'h000001;
          // Maintain only bridges the idle part of the train
          if (state_r == ST_DELAY || state_r == ST_WAIT)
            settle_r <= settle_en_i && ((state_r == ST_WAIT &&
              settle_hold_i) || (cnt_r + pre_settle_i >= delay_i) ||
              (post_run_r && post_r < post_settle_i));
          else
            settle_r <= settle_en_i;
          if (step_done) begin
            cnt_r <= 24'h000000;
            // Pulse start: train period is measured start to start
            if (state_r == ST_DELAY || state_r == ST_WAIT)
              per_r <= 24'h000000;
            if (phase_nxt != ST_IDLE) begin
              state_r <= phase_nxt;
            end else begin
              post_run_r <= 1'b1;
              post_r <= 24'h000000;
              pulses_r <= pulses_r - 8'h01;
              if (pulses_r > 8'h01)
                state_r <= ST_WAIT;
              else
                state_r <= ST_IDLE;
            end
          end
        end
        ST_SEG: begin
          {settle_r, recov_r} <= seg_ctl_m[seg_r];
          cnt_r <= cnt_r + 24'h000001;
          if (cnt_r + 24'h000001 >= seg_len_m[seg_r]) begin
            cnt_r <= 24'h000000;
            if (seg_r == loop_end_i && rep_r != 16'h0000) begin
              seg_r <= loop_start_i;
              if (rep_r != `SWS_REP_INF)
                rep_r <= rep_r - 16'h0001;
            end else if (seg_r == seg_last_i) begin
              state_r <= ST_IDLE;
            end else begin
              seg_r <= seg_r + 3'h1;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Outputs steered by build options
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      amp_o <= 16'h0000;
      chan_o <= 4'h0;
      fast_settle_o <= 1'b0;
      cutoff_switch_o <= 1'b0;
      recov_switch_o <= 1'b0;
      recov_limit_o <= 1'b0;
      active_o <= 1'b0;
    end else begin
      amp_o <= amp_r;
      chan_o <= channel_i[3:0];
      fast_settle_o <= settle_r && (TRAD_FAST_SETTLE != 0);
      cutoff_switch_o <= settle_r && (TRAD_FAST_SETTLE == 0);
      recov_switch_o <= recov_r && (RECOVERY_SWITCH != 0);
      recov_limit_o <= recov_r && (RECOVERY_SWITCH == 0);
      active_o <= (state_r != ST_IDLE);
    end
  end

endmodule // sws_sequencer
`default_nettype wire

// ==== hw/sws_defs.vh ====
// Purpose: constants for the stimulation waveform sequencer
// Assumes: timestep is one pulse of the sample tick input
// Notes: widths are fixed; counts are in timesteps
`ifndef SWS_DEFS_VH
`define SWS_DEFS_VH
`define SWS_NUM_CHAN 16
`define SWS_CHAN_W 5
`define SWS_TRIG_W 2
`define SWS_TRIG_NONE 2'h0
`define SWS_TRIG_BUTTON 2'h1
`define SWS_NUM_SLOTS 2'h2
`define SWS_AMP_W 16
`define SWS_CNT_W 24
`define SWS_PULSE_W 8
`define SWS_MAX_PULSES 8'h63
`define SWS_SEG_NUM 8
`define SWS_SEG_AW 3
`define SWS_REP_W 16
`define SWS_REP_INF 16'hffff
`define SWS_SAMPLE_HZ 20000
`endif

// ==== testbench/sws_seq_chk_sva.sv ====
// Purpose: port checks for the waveform sequencer
// Assumes: outputs follow the tick edge by one clock
// Notes: flags are sticky, so reset is the only way out
`timescale 1ns/10ps
`default_nettype none
`include "sws_defs.vh"
module sws_seq_chk (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire tick_i,
  input wire enable_i,
  input wire [1:0] trig_source_i,
  input wire [4:0] channel_i,
  input wire [7:0] num_pulses_i,
  input wire recov_en_i,
  input wire [23:0] recov_on_i,
  input wire [23:0] recov_off_i,
  input wire [15:0] amp_o,
  input wire active_o,
  input wire refractory_o,
  input wire bad_waveform_flag
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // Bad configurations are caught within two clocks and never released
  a_flag_sticky: assert property (bad_waveform_flag |=> bad_waveform_flag)
    else $error("error flag dropped");
  a_chan_range: assert property (enable_i && channel_i > 5'h0f
    |-> ##[1:2] bad_waveform_flag) else $error("bad channel accepted");
  a_pulse_cap: assert property (enable_i && num_pulses_i > `SWS_MAX_PULSES
    |-> ##[1:2] bad_waveform_flag) else $error("pulse count accepted");
  a_recov_order: assert property (enable_i && recov_en_i
    && recov_off_i < recov_on_i |-> ##[1:2] bad_waveform_flag)
    else $error("recovery order accepted");
  // Only the button source may start a waveform
  a_no_trigger: assert property (enable_i && !active_o
    && trig_source_i != `SWS_TRIG_BUTTON |=> !active_o)
    else $error("inert source started");
  a_refr_quiet: assert property (refractory_o && !active_o
    |=> !$rose(active_o)) else $error("start while refractory");
  // Changes land just after a tick, never between ticks
  a_amp_on_tick: assert property (active_o && $changed(amp_o)
    |-> $past(tick_i) || $past(tick_i, 2)) else $error("amp off tick");
  a_start_tick: assert property ($rose(active_o)
    |-> $past(tick_i) || $past(tick_i, 2)) else $error("start off tick");
  c_start: cover property ($rose(active_o));
  c_refr: cover property ($rose(refractory_o));
  c_error: cover property ($rose(bad_waveform_flag));
endmodule // sws_seq_chk
bind sws_sequencer sws_seq_chk i_chk (.clk_sys_i, .rstn_i, .tick_i,
  .enable_i, .trig_source_i, .channel_i, .num_pulses_i, .recov_en_i,
  .recov_on_i, .recov_off_i, .amp_o, .active_o, .refractory_o,
  .bad_waveform_flag);
`default_nettype wire

// ==== testbench/sws_amp_model.sv ====
// Purpose: sample tick source and amplifier side of the sequencer
// Assumes: amplitude is settled two clocks after a tick
// Notes: TICK_DIV shortens the sample period for simulation
`timescale 1ns/10ps
`default_nettype none
module sws_amp_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [15:0] amp_i,
  output var logic tick_o,
  output var logic [15:0] amp_seen_o
);
  logic [7:0] cnt_r;
  logic [1:0] dly_r;
  // One tick per sample period; the write is taken once amp has landed
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cnt_r <= 8'h00;
      tick_o <= 1'b0;
      dly_r <= 2'h0;
    end else begin
      cnt_r <= (cnt_r == TICK_DIV - 1) ? 8'h00 : cnt_r + 8'h01;
      tick_o <= (cnt_r == TICK_DIV - 1);
      dly_r <= {dly_r[0], tick_o};
      if (dly_r[1]) amp_seen_o <= amp_i;
    end
  end
endmodule // sws_amp_model
`default_nettype wire

// ==== testbench/stim_waveform_sequencer_bench.sv ====
// Purpose: self-checking bench for the waveform sequencer
// Assumes: amplitude sampled per tick by the amplifier model
// Notes: error cases come last since a halt needs a reset
`timescale 1ns/10ps
`default_nettype none
`include "sws_defs.vh"
module stim_waveform_sequencer_bench;
  logic clk_sys_i = 1'b0;
  logic rstn_i, tick_i, enable_i, seg_mode_i, button_trigger_pin, seg_we_i;
  logic settle_en_i, settle_hold_i, recov_en_i, seg_settle_i, seg_recov_i;
  logic fast_settle_o, cutoff_switch_o, recov_switch_o, recov_limit_o;
  logic active_o, refractory_o, bad_waveform_flag, error_led_o;
  logic [1:0] trig_source_i;
  logic [2:0] seg_waddr_i, seg_last_i, loop_start_i, loop_end_i;
  logic [3:0] chan_o;
  logic [4:0] channel_i;
  logic [7:0] num_pulses_i;
  logic [15:0] rest_amp_i, ph1_amp_i, ph2_amp_i, seg_amp_i, loop_rep_i;
  logic [15:0] amp_o, amp_seen;
  logic [23:0] train_period_i, delay_i, ph1_dur_i, gap_dur_i, ph2_dur_i;
  logic [23:0] refr_i, pre_settle_i, post_settle_i, recov_on_i;
  logic [23:0] recov_off_i, seg_len_i;
  int errors = 0, samples_checked = 0, n_act, k;
  int expq[$];
  int sa[8], sl[8];
  always #5 clk_sys_i = ~clk_sys_i;
  sws_sequencer i_dut (.clk_sys_i, .rstn_i, .tick_i, .enable_i, .seg_mode_i,
    .button_trigger_pin, .trig_source_i, .channel_i, .num_pulses_i,
    .train_period_i, .rest_amp_i, .ph1_amp_i, .ph2_amp_i, .delay_i,
    .ph1_dur_i, .gap_dur_i, .ph2_dur_i, .refr_i, .settle_en_i,
    .pre_settle_i, .post_settle_i, .settle_hold_i, .recov_en_i, .recov_on_i,
    .recov_off_i, .seg_we_i, .seg_waddr_i, .seg_len_i, .seg_amp_i,
    .seg_settle_i, .seg_recov_i, .seg_last_i, .loop_start_i, .loop_end_i,
    .loop_rep_i, .amp_o, .chan_o, .fast_settle_o, .cutoff_switch_o,
    .recov_switch_o, .recov_limit_o, .active_o, .refractory_o,
    .bad_waveform_flag, .error_led_o);
  sws_amp_model #(.TICK_DIV(4)) i_amp (.clk_sys_i, .rstn_i, .amp_i(amp_o),
    .tick_o(tick_i), .amp_seen_o(amp_seen));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset;
    rstn_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    rstn_i = 1'b1;
  endtask
  // Valid single-pulse setup; enable low so config may change
  task automatic cfg_base;
    enable_i = 1'b0;
    {seg_mode_i, button_trigger_pin, settle_en_i, settle_hold_i} = 4'h0;
    {recov_en_i, seg_we_i, seg_settle_i, seg_recov_i} = 4'h0;
    {seg_waddr_i, seg_last_i, loop_start_i, loop_end_i} = 12'h000;
    trig_source_i = `SWS_TRIG_BUTTON;
    channel_i = 5'h0f;
    num_pulses_i = 8'h01;
    refr_i = 24'h000003;
    {rest_amp_i, ph1_amp_i, ph2_amp_i, seg_amp_i, loop_rep_i} = 80'h0;
    {train_period_i, delay_i, ph1_dur_i, gap_dur_i, ph2_dur_i} = 120'h0;
    {pre_settle_i, post_settle_i, recov_on_i, recov_off_i, seg_len_i} = 120'h0;
  endtask
  task automatic wait_tick;
    k = 0;
    do @(posedge clk_sys_i); while (tick_i !== 1'b1 && ++k < 8);
    if (k >= 8) errors++;
  endtask
  // Enable, trigger, then compare one amplitude per tick
  task automatic arm_run(input string what);
    @(negedge clk_sys_i);
    enable_i = 1'b1;
    wait_tick;
    @(negedge clk_sys_i);
    button_trigger_pin = 1'b1;
    wait_tick;
    foreach (expq[i]) begin
      if (i > 0) wait_tick;
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      check(amp_seen, expq[i], what);
      // Extra edges while busy must be ignored
      button_trigger_pin = (i < n_act - 1) ? ~button_trigger_pin : 1'b0;
    end
  endtask
  task automatic build_bi;
    expq.delete();
    for (int p = 0; p < num_pulses_i; p++) begin
      while (expq.size() < delay_i + 1 + p * train_period_i)
        expq.push_back(rest_amp_i);
      repeat (ph1_dur_i) expq.push_back(ph1_amp_i);
      repeat (gap_dur_i) expq.push_back(rest_amp_i);
      repeat (ph2_dur_i) expq.push_back(ph2_amp_i);
    end
    n_act = expq.size();
    repeat (6) expq.push_back(rest_amp_i);
  endtask
  // An endless loop never drops reps to zero within the limit
  task automatic build_seg(input int limit);
    int idx, reps;
    expq.delete();
    idx = 1;
    reps = loop_rep_i;
    while (idx <= seg_last_i && expq.size() < limit) begin
      repeat (sl[idx]) expq.push_back(sa[idx]);
      if (idx == loop_end_i && reps != 0) begin
        reps--;
        idx = loop_start_i;
      end else idx++;
    end
    n_act = expq.size();
    if (n_act < limit) repeat (6) expq.push_back(sa[0]);
  endtask
  initial begin
    #200000;
    errors++;
    summarize;
  end
  initial begin
    void'($urandom(57401));
    cfg_base;
    do_reset;
    for (int r = 0; r < 6; r++) begin
      cfg_base;
      {ph1_amp_i, ph2_amp_i, rest_amp_i} = {$urandom, 16'($urandom)};
      delay_i = 24'(2 + $urandom % 2);
      ph1_dur_i = 24'($urandom % 3);
      gap_dur_i = 24'($urandom % 3);
      ph2_dur_i = 24'($urandom % 3);
      num_pulses_i = 8'(1 + r % 2);
      train_period_i = (r % 2) ? 24'h000008 : 24'h000000;
      {settle_en_i, recov_en_i} = 2'((r + 1) / 2);
      {pre_settle_i, post_settle_i} = {2{23'h0, settle_en_i}};
      settle_hold_i = settle_en_i;
      recov_on_i = {23'h0, recov_en_i};
      recov_off_i = {22'h0, recov_en_i, 1'b0};
      build_bi;
      arm_run("biphasic amp");
      check(chan_o, channel_i[3:0], "channel");
      check({active_o, bad_waveform_flag}, 2'h0, "idle after run");
      check({cutoff_switch_o, recov_limit_o}, 2'h0, "build opts");
    end
    // No-trigger source 0 and reserved source 2 hold the resting level
    for (int s = 0; s < 3; s += 2) begin
      cfg_base;
      trig_source_i = 2'(s);
      expq = '{8{0}};
      n_act = 8;
      arm_run("inert source");
    end
    cfg_base;
    seg_mode_i = 1'b1;
    for (int s = 0; s < 4; s++) begin
      @(negedge clk_sys_i);
      sl[s] = 1 + $urandom % 2;
      sa[s] = $urandom % 65536;
      {seg_we_i, seg_waddr_i, seg_settle_i, seg_recov_i} = {1'b1, 3'(s), 2'(s)};
      {seg_len_i, seg_amp_i} = {24'(sl[s]), 16'(sa[s])};
    end
    @(negedge clk_sys_i);
    {seg_we_i, seg_last_i, loop_start_i, loop_end_i} = {1'b0, 9'o323};
    loop_rep_i = 16'h0001;
    build_seg(64);
    arm_run("segment amp");
    enable_i = 1'b0;
    loop_rep_i = `SWS_REP_INF;
    build_seg(24);
    arm_run("endless loop");
    // Each bad field alone halts with both indicators lit
    for (int e = 0; e < 6; e++) begin
      cfg_base;
      do_reset;
      check({bad_waveform_flag, error_led_o}, 2'h0, "flags after reset");
      case (e)
        0: channel_i = 5'h10;
        1: num_pulses_i = 8'h64;
        2: {recov_en_i, recov_on_i, recov_off_i} = {1'b1, 48'h2_000001};
        3: pre_settle_i = 24'h000001;
        4: {settle_en_i, post_settle_i, delay_i} = {1'b1, 48'h4_000004};
        default: train_period_i = 24'h000005;
      endcase
      @(negedge clk_sys_i);
      enable_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      check({bad_waveform_flag, error_led_o}, 2'h3, "error flags");
    end
    summarize;
  end
endmodule // stim_waveform_sequencer_bench
`default_nettype wire
